/* rtl/rct_cfg.svh */
// Register offsets, field positions, reset values and counts for the timer
// Assumes inclusion by bare name from the timer's design files
`ifndef RCT_CFG_SVH
`define RCT_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define RCT_OFF_CTRL 12'h000
`define RCT_OFF_RELOAD 12'h004
`define RCT_OFF_COUNT 12'h008
`define RCT_OFF_STATUS 12'h00C
`define RCT_OFF_MASK 12'h010
`define RCT_OFF_PIN 12'h014

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define RCT_CTRL_RUN 0
`define RCT_CTRL_CAPTURE 1
`define RCT_CTRL_UPDOWN 2
`define RCT_CTRL_EXT_EN 3
`define RCT_CTRL_RISING 4
`define RCT_CTRL_PRE_EN 5
`define RCT_CTRL_PRE_LO 6
`define RCT_CTRL_PRE_HI 8

// ----------------------------------------------------------------------
// Status fields, reset values and counts
// ----------------------------------------------------------------------
`define RCT_ST_RELOAD 0
`define RCT_ST_CAPTURE 1
`define RCT_ST_EXTEDGE 2
`define RCT_CTRL_RST 32'h0000_0000
`define RCT_WORD_RST 16'h0000
`define RCT_TOP 16'hFFFF
`define RCT_DIV_OFF 12
`define RCT_DIV_W 4

`endif

/* rtl/rct_pkg.sv */
// Types shared by the timer modules
// Assumes nothing beyond the config header
package rct_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic {
    MODE_RELOAD,
    MODE_CAPTURE
  } mode_e;
endpackage : rct_pkg

/* rtl/rct_tick_if.sv */
// Count-enable carrier between the prescaler and the counter core
// Assumes one clock domain
`timescale 1ns/10ps
interface rct_tick_if;
  logic run;
  logic pre_en;
  logic [2:0] pre_sel;
  logic tick;
  modport src (input run, input pre_en, input pre_sel, output tick);
  modport dst (output run, output pre_en, output pre_sel, input tick);
endinterface : rct_tick_if

/* rtl/rct_prescaler.sv */
// Count-rate prescaler: fixed divide by twelve, or 2^n when enabled
// Assumes clk_i is the peripheral clock
`timescale 1ns/10ps
`include "rct_cfg.svh"
module rct_prescaler (
  input wire logic clk_i,
  input wire logic rst_i,
  rct_tick_if.src tk
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] limit;
  logic wrap;

  assign limit = tk.pre_en ? 8'((1 << tk.pre_sel) - 1)
                           : 8'(`RCT_DIV_OFF - 1); // [R2]
  assign wrap = (cnt_q >= limit);
  assign cnt_d = (!tk.run || wrap) ? 8'h00 : cnt_q + 8'h01;
  assign tk.tick = tk.run && wrap;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : rct_prescaler

/* rtl/reload_capture_timer.sv */
// Reload/capture timer with APB register access and one interrupt line
// Assumes APB master on clk_i; trigger pin synchronous to nothing
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "rct_cfg.svh"

// What this block does
// (R1) 16-bit counter in auto-reload or single-channel capture mode.
// (R2) With prescaler off the counter advances once per twelve clocks.
// (R3) Counting continues while enabled; no self-stop on any event.
// (R4) Reload mode, no up/down: count up from reload value to FFFF.
// (R5) Reload trigger: overflow only, or also selected pin edge.
// (R6) Reload value comes from the software-written reload/capture register.
// (R7) Reload mode, no up/down: every reload raises the interrupt.
// (R8) Up/down mode: pin level sets direction; reloads raise no interrupt.
// (R9) Up/down counting up: reload from reload value on overflow.
// (R10) Counting down: underflow at reload value, then reload to FFFF.
// (R11) Capture mode counts 0000 to FFFF and reloads zero.
// (R12) Capture mode: selected pin edge copies count into reload register.
// (R13) Capture mode: reload and capture events both raise the interrupt.
// (R14) Trigger pin is synchronised before edge or level use.
module reload_capture_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic external_trigger_pin_i,
  output logic irq_o
);
  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [9:0] ctrl_q;
  rct_pkg::word_t reload_capture_value_q;
  rct_pkg::word_t timer_count_value_q;
  logic [2:0] status_q;
  logic [2:0] mask_q;
  logic [2:0] pin_sync_q;
  logic [31:0] prdata_q;

  rct_tick_if tk ();

  rct_prescaler u_pre (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tk(tk)
  );

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  wire acc = psel_i && penable_i;
  wire wr = acc && pwrite_i;
  wire rd = acc && !pwrite_i;
  wire hit_ctrl = (paddr_i == `RCT_OFF_CTRL);
  wire hit_rel = (paddr_i == `RCT_OFF_RELOAD);
  wire hit_cnt = (paddr_i == `RCT_OFF_COUNT);
  wire hit_st = (paddr_i == `RCT_OFF_STATUS);
  wire hit_mask = (paddr_i == `RCT_OFF_MASK);
  wire hit_pin = (paddr_i == `RCT_OFF_PIN);
  wire mapped = hit_ctrl | hit_rel | hit_cnt | hit_st | hit_mask | hit_pin;

  assign pready_o = 1'b1;
  assign pslverr_o = acc && !mapped;
  assign prdata_o = prdata_q;

  // --------------------------------------------------------------------
  // Control fields
  // --------------------------------------------------------------------
  wire run = ctrl_q[`RCT_CTRL_RUN];
  rct_pkg::mode_e mode;
  assign mode = ctrl_q[`RCT_CTRL_CAPTURE] ? rct_pkg::MODE_CAPTURE
                                          : rct_pkg::MODE_RELOAD; // [R1]
  wire updown = ctrl_q[`RCT_CTRL_UPDOWN] && (mode == rct_pkg::MODE_RELOAD);
  wire ext_en = ctrl_q[`RCT_CTRL_EXT_EN];
  wire rising = ctrl_q[`RCT_CTRL_RISING];

  assign tk.run = run; // [R3]
  assign tk.pre_en = ctrl_q[`RCT_CTRL_PRE_EN];
  assign tk.pre_sel = ctrl_q[`RCT_CTRL_PRE_HI:`RCT_CTRL_PRE_LO];

  // --------------------------------------------------------------------
  // Trigger pin synchroniser and edge select
  // --------------------------------------------------------------------
  // Stage 0 feeds only stage 1; level and edges use stages 1 and 2
  wire pin_lvl = pin_sync_q[1]; // [R14]
  wire pin_rise = pin_sync_q[1] && !pin_sync_q[2];
  wire pin_fall = !pin_sync_q[1] && pin_sync_q[2];
  wire pin_edge = ext_en && (rising ? pin_rise : pin_fall);

  // --------------------------------------------------------------------
  // Count path
  // --------------------------------------------------------------------
  wire tick = tk.tick;
  wire count_down = updown && !pin_lvl; // [R8]
  wire at_top = (timer_count_value_q == `RCT_TOP);
  wire at_floor = (timer_count_value_q == reload_capture_value_q);
  wire ovf = tick && !count_down && at_top;
  wire unf = tick && count_down && at_floor; // [R10]
  // Pin-triggered reload only in plain reload mode
  wire ext_reload = pin_edge && (mode == rct_pkg::MODE_RELOAD) &&
                    !updown; // [R5]
  wire capture_ev = pin_edge && (mode == rct_pkg::MODE_CAPTURE); // [R12]
  wire reload_ev = run && (ovf || unf || ext_reload);

  rct_pkg::word_t reload_val;
  assign reload_val = (mode == rct_pkg::MODE_CAPTURE) ? `RCT_WORD_RST
                    : count_down ? `RCT_TOP
                    : reload_capture_value_q; // [R4] [R6] [R9] [R10] [R11]

  rct_pkg::word_t count_d;
  assign count_d = (wr && hit_cnt) ? pwdata_i[15:0]
                 : reload_ev ? reload_val
                 : !tick ? timer_count_value_q
                 : count_down ? timer_count_value_q - 16'h0001
                 : timer_count_value_q + 16'h0001; // [R3] [R4]

  rct_pkg::word_t rc_d;
  assign rc_d = (run && capture_ev) ? timer_count_value_q
              : (wr && hit_rel) ? pwdata_i[15:0]
              : reload_capture_value_q; // [R12]

  // --------------------------------------------------------------------
  // Events and interrupt
  // --------------------------------------------------------------------
  logic [2:0] ev;
  assign ev[`RCT_ST_RELOAD] = reload_ev && !updown; // [R7] [R8] [R13]
  assign ev[`RCT_ST_CAPTURE] = run && capture_ev; // [R13]
  assign ev[`RCT_ST_EXTEDGE] = pin_edge;

  wire [2:0] st_clr = (wr && hit_st) ? pwdata_i[2:0] : 3'h0;
  wire [2:0] status_d = (status_q & ~st_clr) | ev;
  assign irq_o = |(status_q & mask_q);

  // --------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------
  logic [31:0] rd_word;
  assign rd_word = hit_ctrl ? {22'h00_0000, ctrl_q}
                 : hit_rel ? {16'h0000, reload_capture_value_q}
                 : hit_cnt ? {16'h0000, timer_count_value_q}
                 : hit_st ? {29'h0000_0000, status_q}
                 : hit_mask ? {29'h0000_0000, mask_q}
                 : hit_pin ? {31'h0000_0000, pin_lvl}
                 : 32'h0000_0000;

  // --------------------------------------------------------------------
  // Flops
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= 10'(`RCT_CTRL_RST);
      mask_q <= 3'h0;
    end else if (wr && hit_ctrl) begin
      ctrl_q <= pwdata_i[9:0];
    end else if (wr && hit_mask) begin
      mask_q <= pwdata_i[2:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_count_value_q <= `RCT_WORD_RST;
      reload_capture_value_q <= `RCT_WORD_RST;
      status_q <= 3'h0;
    end else begin
      timer_count_value_q <= count_d;
      reload_capture_value_q <= rc_d;
      status_q <= status_d;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_sync_q <= 3'h0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], external_trigger_pin_i}; // [R14]
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_q <= rd_word;
    end
  end
endmodule : reload_capture_timer

/* dv/rct_trig_src.sv */
// Trigger pin source standing in for the outside world
// Assumes want_i changes just after a rising clock edge
`timescale 1ns/10ps
module trig_src (
  input wire logic clk_i,
  input wire logic want_i,
  output logic pin_o
);
  logic [1:0] age_q = 2'd0;
  initial pin_o = 1'b0;
  // Levels held at least three clocks so no edge slips past the synchroniser
  always @(posedge clk_i) begin
    if (age_q != 2'd2) age_q <= age_q + 2'd1;
    if (want_i != pin_o && age_q == 2'd2) begin
      pin_o <= want_i;
      age_q <= 2'd0;
    end
  end
endmodule : trig_src

/* dv/rct_chk.sv */
// Checker on the timer's bus and interrupt ports
// Assumes a bind onto reload_capture_timer
`timescale 1ns/10ps
module rct_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic external_trigger_pin_i,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rs_q;
  wire acc = psel_i && penable_i;
  wire wr = acc && pwrite_i;
  wire hi = paddr_i > 12'h014;
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i) rs_q <= 1'b0;
    else rs_q <= psel_i && !penable_i && !pwrite_i;
  ready_high_a: assert property (pready_o) else $error("ready low");
  err_place_a: assert property (pslverr_o |-> acc) else $error("stray err");
  err_hole_a: assert property (acc && hi |-> pslverr_o) else $error("no err");
  err_none_a: assert property (acc && !hi && paddr_i[1:0] == 2'b00
    |-> !pslverr_o) else $error("false err");
  hole_zero_a: assert property (acc && !pwrite_i && pslverr_o
    |-> prdata_o == 32'h0000_0000) else $error("hole data");
  upper_zero_a: assert property (acc && !pwrite_i
    |-> prdata_o[31:16] == 16'h0000) else $error("upper bits");
  rdata_hold_a: assert property ($changed(prdata_o) |-> rs_q)
    else $error("read data moved");
  mask_off_a: assert property (wr && paddr_i == 12'h010
    && pwdata_i[2:0] == 3'b000 |=> !irq_o) else $error("irq masked");
  irq_fall_a: assert property ($fell(irq_o) |-> $past(wr))
    else $error("irq dropped");
  cover property (acc && pslverr_o);
  cover property ($rose(irq_o));
  cover property ($fell(irq_o));
endmodule : rct_chk
bind reload_capture_timer rct_chk chk (.clk_i, .rst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
  .pslverr_o, .external_trigger_pin_i, .irq_o);

/* dv/tb.sv */
// Self-checking bench for the reload/capture timer
// Assumes design, checker and trigger source compiled first
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  err_total++; $display("CHECK FAILED %0t %h %h", $time, g, e); end end
module tb;
  logic clk, rst, psel, pen, pwr, want, pin, rdy, serr, irq, se;
  logic [11:0] addr;
  logic [15:0] lo;
  logic [31:0] wdat, rdat, r, rnd;
  int err_total, comparisons;
  int mdl [6];
  reload_capture_timer dut (.clk_i(clk), .rst_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdat),
    .prdata_o(rdat), .pready_o(rdy), .pslverr_o(serr),
    .external_trigger_pin_i(pin), .irq_o(irq));
  trig_src src (.clk_i(clk), .want_i(want), .pin_o(pin));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction : xs
  // One idle cycle before each setup keeps psel single-driven per step
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    r = rdat;
    se = serr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (w && a < 12'h018 && a != 12'h008 && a != 12'h00C)
      mdl[a[4:2]] = d & 32'h0000_FFFF;
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(r, e)
  endtask : rdc
  task automatic test_done();
    if (err_total == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    test_done();
  end
  initial begin
    {rst, psel, pen, pwr, want, addr, wdat} = {5'b10000, 44'h0};
    rnd = 32'h94aa_b981;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++)
      rdc(12'(i * 4), 32'h0000_0000);
    apb(1'b0, 12'h020, 32'h0000_0000);
    `CHK({se, r}, 33'h1_0000_0000)
    rnd = xs(rnd);
    apb(1'b1, 12'h004, rnd);
    rdc(12'h004, mdl[1]);
    apb(1'b1, 12'h008, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0001);
    repeat (240) @(posedge clk);
    apb(1'b1, 12'h000, 32'h0000_0000);
    apb(1'b0, 12'h008, 32'h0000_0000);
    `CHK(r >= 19 && r <= 21, 1'b1)
    apb(1'b1, 12'h010, 32'h0000_0007);
    apb(1'b1, 12'h004, 32'h0000_FFF0);
    apb(1'b1, 12'h008, 32'h0000_FFFC);
    apb(1'b1, 12'h000, 32'h0000_0021);
    repeat (8) @(posedge clk);
    `CHK(irq, 1'b1)
    apb(1'b1, 12'h000, 32'h0000_0000);
    apb(1'b0, 12'h008, 32'h0000_0000);
    `CHK(r >= 16'hFFF0 && r < 16'hFFFC, 1'b1)
    rdc(12'h00C, 32'h0000_0001);
    apb(1'b1, 12'h00C, 32'h0000_0007);
    for (int i = 0; i < 2; i++) begin
      want <= i[0];
      apb(1'b1, 12'h004, i ? 32'h0000_0100 : 32'h0000_0003);
      apb(1'b1, 12'h008, i ? 32'h0000_FFFE : 32'h0000_0006);
      apb(1'b1, 12'h000, 32'h0000_0025);
      repeat (10) @(posedge clk);
      apb(1'b1, 12'h000, 32'h0000_0000);
      apb(1'b0, 12'h008, 32'h0000_0000);
      lo = i ? 16'h0100 : 16'hFFF0;
      `CHK(r >= lo && r < lo + 16, 1'b1)
      rdc(12'h00C, 32'h0000_0000);
    end
    want <= 1'b0;
    repeat (6) @(posedge clk);
    apb(1'b1, 12'h00C, 32'h0000_0007);
    apb(1'b1, 12'h010, 32'h0000_0000);
    apb(1'b1, 12'h008, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_003B);
    want <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK(irq, 1'b0)
    apb(1'b1, 12'h010, 32'h0000_0007);
    apb(1'b1, 12'h000, 32'h0000_0000);
    `CHK(irq, 1'b1)
    rdc(12'h00C, 32'h0000_0006);
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK(r > 0 && r < 16, 1'b1)
    apb(1'b1, 12'h00C, 32'h0000_0007);
    rdc(12'h00C, 32'h0000_0000);
    rdc(12'h014, 32'h0000_0001);
    apb(1'b1, 12'h004, 32'h0000_0040);
    rdc(12'h004, mdl[1]);
    apb(1'b1, 12'h008, 32'h0000_0010);
    apb(1'b1, 12'h000, 32'h0000_0029);
    want <= 1'b0;
    repeat (10) @(posedge clk);
    apb(1'b1, 12'h000, 32'h0000_0000);
    apb(1'b0, 12'h008, 32'h0000_0000);
    `CHK(r >= 16'h0040 && r < 16'h0050, 1'b1)
    rdc(12'h00C, 32'h0000_0005);
    apb(1'b1, 12'h00C, 32'h0000_0007);
    test_done();
  end
endmodule : tb
